/* File: inc/mis_pkg.sv */
// constants, types and helpers for the instruction datapath slice
// ------------------------------------------------------------------
// What this block does
// - add-with-carry to working register: W+M+C into W, four flags.
// - add-with-carry to memory: W+M+C into M, four flags.
// - plain add M to W, no carry in, result in W, four flags.
// - add immediate to W, no carry in, result in W, four flags.
// - add W to M, no carry in, result in M, four flags.
// - AND of W with memory byte into W, only zero flag changes.
// - AND of W with immediate into W, only zero flag changes.
// - AND of memory byte with W written back to that memory byte.
// - call pushes next address (counter plus 1), loads target, no flags.
// - call takes two instruction cycles for the address load slot.
// - zeroing op writes 00 to the memory byte, flags untouched.
// - bit zeroing clears only selected bit of memory byte, no flags.
// - watchdog clear resets counter, sleep flag and expired flag, except that an expiry in the same cycle leaves the expired flag set.
// - invert op complements memory byte in place, updates only zero flag.
// ------------------------------------------------------------------
package mis_pkg;

   localparam int DW = 8;
   localparam int MAW = 6;
   localparam int PCW = 10;
   localparam int AW = 5;
   localparam int STK_N = 4;
   localparam int WDW = 16;

   // register byte offsets
   localparam logic [AW-1:0] OFS_CMD = 5'h00;
   localparam logic [AW-1:0] OFS_WREG = 5'h04;
   localparam logic [AW-1:0] OFS_STAT = 5'h08;
   localparam logic [AW-1:0] OFS_PC = 5'h0C;
   localparam logic [AW-1:0] OFS_MADDR = 5'h10;
   localparam logic [AW-1:0] OFS_MDATA = 5'h14;
   localparam logic [AW-1:0] OFS_DOG = 5'h18;
   localparam logic [AW-1:0] OFS_STACK = 5'h1C;

   // command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BIT_LSB = 4;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_IMM_LSB = 16;

   // status bit positions
   localparam int ST_C = 0;
   localparam int ST_HC = 1;
   localparam int ST_Z = 2;
   localparam int ST_SX = 3;
   localparam int ST_SLP = 4;
   localparam int ST_WDX = 5;
   localparam int ST_BUSY = 6;
   localparam int STK_CNT_LSB = 16;

   // reset values
   localparam logic [DW-1:0] WREG_RST = 8'h00;
   localparam logic [PCW-1:0] PC_RST = 10'h000;
   localparam logic [MAW-1:0] MADDR_RST = 6'h00;
   localparam int DOG_LIMIT_DEF = 65535;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_ADC = 4'h1,
      OP_ADC_MEM = 4'h2,
      OP_ADD = 4'h3,
      OP_ADDI = 4'h4,
      OP_ADD_MEM = 4'h5,
      OP_AND = 4'h6,
      OP_ANDI = 4'h7,
      OP_AND_MEM = 4'h8,
      OP_CALL = 4'h9,
      OP_CLRM = 4'hA,
      OP_CLRB = 4'hB,
      OP_CLRWDT = 4'hC,
      OP_INV = 4'hD
   } mis_op_t;

   typedef enum logic [1:0] {
      S_IDLE,
      S_FETCH,
      S_EXEC,
      S_CALL2
   } mis_state_t;

   // returns {signed excess, half carry, carry, sum[7:0]}
   function automatic logic [DW+2:0] mis_add8(input logic [DW-1:0] a,
                                              input logic [DW-1:0] b,
                                              input logic cin);
      logic [DW:0] full;
      logic [4:0] low;
      logic sx;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      sx = (a[7] == b[7]) && (full[7] != a[7]);
      return {sx, low[4], full[8], full[7:0]};
   endfunction

   function automatic logic [31:0] mis_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

/* File: hw/mis_dmem.sv */
// data memory: one write port, registered read port
`timescale 1ns/1ps
`default_nettype none
module mis_dmem
   import mis_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [MAW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [MAW-1:0] raddr,
   output logic [DW-1:0] rdata_q
);

   logic [DW-1:0] mem [0:(1<<MAW)-1];

   // array holds no reset, contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= 8'h00;
      end
      else
      begin
         rdata_q <= mem[raddr];
      end
   end

endmodule
`default_nettype wire

/* File: hw/mis_alu_top.sv */
// instruction datapath slice with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mis_alu_top
   import mis_pkg::*;
#(
   parameter int DOG_LIMIT = DOG_LIMIT_DEF
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [AW-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [AW-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rs1_q;
   logic rs2_q;
   logic rst_n;

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end
      else
      begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end

   assign rst_n = rs2_q;

   // ------------------------------------------------------------
   // state declarations
   // ------------------------------------------------------------
   mis_state_t state_q;
   mis_state_t state_d;
   mis_op_t op_q;
   logic [2:0] bit_q;
   logic [MAW-1:0] addr_q;
   logic [PCW-1:0] imm_q;
   logic [DW-1:0] wreg_q;
   logic c_q;
   logic hc_q;
   logic z_q;
   logic sx_q;
   logic slp_q;
   logic wdx_q;
   logic [PCW-1:0] pc_q;
   logic [PCW-1:0] stk_q [0:STK_N-1];
   logic [1:0] sp_q;
   logic [2:0] cnt_q;
   logic [MAW-1:0] maddr_q;
   logic [WDW-1:0] dog_q;
   logic [DW-1:0] mem_rdata;

   logic aw_full_q;
   logic [AW-1:0] aw_addr_q;
   logic w_full_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic rsel_mem_q;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire idle = (state_q == S_IDLE);
   // no write while a read answer is pending or an instruction runs
   wire do_wr = aw_full_q & w_full_q & ~bvalid_q & ~rvalid_q & idle;
   wire [AW-1:0] wa = {aw_addr_q[AW-1:2], 2'b00};
   wire wr_cmd = do_wr & (wa == OFS_CMD);
   wire wr_wreg = do_wr & (wa == OFS_WREG);
   wire wr_stat = do_wr & (wa == OFS_STAT);
   wire wr_pc = do_wr & (wa == OFS_PC);
   wire wr_maddr = do_wr & (wa == OFS_MADDR);
   wire wr_mdata = do_wr & (wa == OFS_MDATA);
   wire wr_ok = wr_cmd | wr_wreg | wr_stat | wr_pc | wr_maddr | wr_mdata;
   wire [31:0] cmd_v = mis_merge(32'h0, w_data_q, w_strb_q);
   wire [31:0] wreg_v = mis_merge({24'h0, wreg_q}, w_data_q, w_strb_q);
   wire [31:0] stat_v = mis_merge({26'h0, slp_q, 1'b0, sx_q, z_q, hc_q, c_q},
                                  w_data_q, w_strb_q);
   wire [31:0] pc_v = mis_merge({22'h0, pc_q}, w_data_q, w_strb_q);
   wire [31:0] maddr_v = mis_merge({26'h0, maddr_q}, w_data_q, w_strb_q);
   wire [31:0] mdata_v = mis_merge(32'h0, w_data_q, w_strb_q);

   wire do_rd = ARVALID & ARREADY;
   wire [AW-1:0] ra = {ARADDR[AW-1:2], 2'b00};
   wire [1:0] top_idx = sp_q - 2'd1;
   wire [31:0] stat_word = {25'h0, ~idle, wdx_q, slp_q, sx_q, z_q, hc_q, c_q};
   wire [31:0] stk_word = {13'h0, cnt_q, 6'h0, stk_q[top_idx]};
   wire rd_known = (ra == OFS_CMD) | (ra == OFS_WREG) | (ra == OFS_STAT) |
                   (ra == OFS_PC) | (ra == OFS_MADDR) | (ra == OFS_MDATA) |
                   (ra == OFS_DOG) | (ra == OFS_STACK);
   wire [31:0] rd_word =
      (ra == OFS_CMD) ? {6'h0, imm_q, 2'h0, addr_q, 1'b0, bit_q, op_q} :
      (ra == OFS_WREG) ? {24'h0, wreg_q} :
      (ra == OFS_STAT) ? stat_word :
      (ra == OFS_PC) ? {22'h0, pc_q} :
      (ra == OFS_MADDR) ? {26'h0, maddr_q} :
      (ra == OFS_DOG) ? {16'h0, dog_q} :
      (ra == OFS_STACK) ? stk_word : 32'h0;

   assign AWREADY = ~aw_full_q;
   assign WREADY = ~w_full_q;
   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;
   // reads wait while an instruction owns the memory port
   assign ARREADY = ~rvalid_q & idle;
   assign RVALID = rvalid_q;
   assign RRESP = rresp_q;
   assign RDATA = rsel_mem_q ? {24'h0, mem_rdata} : rdata_q;

   // ------------------------------------------------------------
   // AXI4-Lite channels
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 5'h00;
         w_full_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else
      begin
         if (AWVALID & ~aw_full_q)
         begin
            aw_full_q <= 1'b1;
            aw_addr_q <= AWADDR;
         end
         else if (do_wr)
         begin
            aw_full_q <= 1'b0;
         end
         if (WVALID & ~w_full_q)
         begin
            w_full_q <= 1'b1;
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
         end
         else if (do_wr)
         begin
            w_full_q <= 1'b0;
         end
         if (do_wr)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (BREADY)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
         rsel_mem_q <= 1'b0;
      end
      else if (do_rd)
      begin
         rvalid_q <= 1'b1;
         rresp_q <= rd_known ? RESP_OKAY : RESP_SLVERR;
         rdata_q <= rd_word;
         rsel_mem_q <= (ra == OFS_MDATA);
      end
      else if (RREADY)
      begin
         rvalid_q <= 1'b0;
         rsel_mem_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // execution datapath
   // ------------------------------------------------------------
   wire exec = (state_q == S_EXEC);
   wire is_adc = (op_q == OP_ADC) | (op_q == OP_ADC_MEM);
   wire is_arith = is_adc | (op_q == OP_ADD) | (op_q == OP_ADDI) | (op_q == OP_ADD_MEM);
   wire is_and = (op_q == OP_AND) | (op_q == OP_ANDI) | (op_q == OP_AND_MEM);
   wire cin = is_adc & c_q;
   // immediate form takes the low byte of the command's immediate field
   wire [DW-1:0] opnd = ((op_q == OP_ADDI) | (op_q == OP_ANDI)) ?
                        imm_q[DW-1:0] : mem_rdata;
   wire [DW+2:0] sum = mis_add8(wreg_q, opnd, cin);
   wire [DW-1:0] sum8 = sum[DW-1:0];
   wire [DW-1:0] andr = wreg_q & opnd;
   wire [DW-1:0] inv = ~mem_rdata;
   wire [DW-1:0] bclr = mem_rdata & ~(8'h01 << bit_q);
   wire wreg_sum = (op_q == OP_ADC) | (op_q == OP_ADD) | (op_q == OP_ADDI);
   wire wreg_and = (op_q == OP_AND) | (op_q == OP_ANDI);
   wire dog_clr = exec & (op_q == OP_CLRWDT);

   logic mem_we_x;
   logic [DW-1:0] mem_wd_x;

   always_comb
   begin
      mem_we_x = 1'b1;
      mem_wd_x = 8'h00;
      unique case (op_q)
         OP_ADC_MEM: mem_wd_x = sum8;
         OP_ADD_MEM: mem_wd_x = sum8;
         OP_AND_MEM: mem_wd_x = andr;
         OP_CLRM: mem_wd_x = 8'h00;
         OP_CLRB: mem_wd_x = bclr;
         OP_INV: mem_wd_x = inv;
         default: mem_we_x = 1'b0;
      endcase
   end

   wire mem_we = (exec & mem_we_x) | wr_mdata;
   wire [MAW-1:0] mem_wa = exec ? addr_q : maddr_q;
   wire [DW-1:0] mem_wd = exec ? mem_wd_x : mdata_v[DW-1:0];
   // idle keeps the software address on the read port for data reads
   wire [MAW-1:0] mem_ra = idle ? maddr_q : addr_q;

   mis_dmem u_dmem (
      .clk(MCLK),
      .rst_n(rst_n),
      .we(mem_we),
      .waddr(mem_wa),
      .wdata(mem_wd),
      .raddr(mem_ra),
      .rdata_q(mem_rdata)
   );

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         S_IDLE: state_d = wr_cmd ? S_FETCH : S_IDLE;
         S_FETCH: state_d = S_EXEC;
         S_EXEC: state_d = (op_q == OP_CALL) ? S_CALL2 : S_IDLE;
         S_CALL2: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= S_IDLE;
         op_q <= OP_NOP;
         bit_q <= 3'h0;
         addr_q <= 6'h00;
         imm_q <= 10'h000;
         maddr_q <= MADDR_RST;
      end
      else
      begin
         state_q <= state_d;
         if (wr_cmd)
         begin
            // codes above the last op run as a no-op
            op_q <= (cmd_v[3:0] > OP_INV) ? OP_NOP : mis_op_t'(cmd_v[3:0]);
            bit_q <= cmd_v[CMD_BIT_LSB +: 3];
            addr_q <= cmd_v[CMD_ADDR_LSB +: MAW];
            imm_q <= cmd_v[CMD_IMM_LSB +: PCW];
         end
         if (wr_maddr)
         begin
            maddr_q <= maddr_v[MAW-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // working register and flags
   // ------------------------------------------------------------
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wreg_q <= WREG_RST;
         c_q <= 1'b0;
         hc_q <= 1'b0;
         z_q <= 1'b0;
         sx_q <= 1'b0;
      end
      else if (wr_wreg)
      begin
         wreg_q <= wreg_v[DW-1:0];
      end
      else if (wr_stat)
      begin
         c_q <= stat_v[ST_C];
         hc_q <= stat_v[ST_HC];
         z_q <= stat_v[ST_Z];
         sx_q <= stat_v[ST_SX];
      end
      else if (exec)
      begin
         if (wreg_sum)
         begin
            wreg_q <= sum8;
         end
         else if (wreg_and)
         begin
            wreg_q <= andr;
         end
         if (is_arith)
         begin
            sx_q <= sum[DW+2];
            hc_q <= sum[DW+1];
            c_q <= sum[DW];
            z_q <= (sum8 == 8'h00);
         end
         else if (is_and)
         begin
            z_q <= (andr == 8'h00);
         end
         else if (op_q == OP_INV)
         begin
            z_q <= (inv == 8'h00);
         end
      end
   end

   // ------------------------------------------------------------
   // watchdog counter and its flags
   // ------------------------------------------------------------
   wire dog_exp = (dog_q == DOG_LIMIT[WDW-1:0]);

   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dog_q <= 16'h0000;
         wdx_q <= 1'b0;
         slp_q <= 1'b0;
      end
      else
      begin
         dog_q <= (dog_clr | dog_exp) ? 16'h0000 : dog_q + 16'h0001;
         // expiry wins over a clear landing in the same cycle
         wdx_q <= dog_exp | (wdx_q & ~dog_clr);
         if (wr_stat)
         begin
            slp_q <= stat_v[ST_SLP];
         end
         else if (dog_clr)
         begin
            slp_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // program counter and return stack
   // ------------------------------------------------------------
   wire [PCW-1:0] pc_next = pc_q + 10'h001;

   // stack is circular: a fifth call overwrites the oldest entry
   always_ff @(posedge MCLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_q <= PC_RST;
         sp_q <= 2'h0;
         cnt_q <= 3'h0;
         for (int i = 0; i < STK_N; i++)
         begin
            stk_q[i] <= PC_RST;
         end
      end
      else if (wr_pc)
      begin
         pc_q <= pc_v[PCW-1:0];
      end
      else if (exec & (op_q == OP_CALL))
      begin
         stk_q[sp_q] <= pc_next;
         sp_q <= sp_q + 2'd1;
         cnt_q <= (cnt_q == 3'd4) ? cnt_q : cnt_q + 3'd1;
      end
      else if (exec)
      begin
         pc_q <= pc_next;
      end
      else if (state_q == S_CALL2)
      begin
         pc_q <= imm_q;
      end
   end

endmodule
`default_nettype wire

/* File: dv/mis_alu_chk.sv */
// bus and timing assertions for the instruction datapath slice
`timescale 1ns/1ps
`default_nettype none
module mis_alu_chk
   import mis_pkg::*;
#(
   parameter int DOG_LIMIT = DOG_LIMIT_DEF
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [AW-1:0] AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [AW-1:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   input wire logic RREADY
);
   default clocking dc @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);

   // quiet bus and idle engine, so the launch edge is the next one
   logic cmd_go;
   assign cmd_go = AWVALID && AWREADY && WVALID && WREADY && AWADDR == OFS_CMD
                   && ARREADY && !ARVALID && !RVALID && !BVALID;

   bvalid_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped or changed");
   rvalid_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped or changed");
   read_latency_a: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   read_block_a: assert property (RVALID |-> !ARREADY)
      else $error("second read accepted while one pending");
   slot_full_a: assert property (AWVALID && AWREADY && !BVALID |=> !AWREADY)
      else $error("address slot not marked full");
   write_resp_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:8] BVALID)
      else $error("write response missing");
   resp_code_a: assert property (BVALID || RVALID |-> BRESP == RESP_OKAY && RRESP == RESP_OKAY)
      else $error("error response on mapped offset");
   call_slot_a: assert property (cmd_go && WDATA[3:0] == 4'h9
         |-> ##2 !ARREADY [*3] ##1 ARREADY)
      else $error("call not two instruction cycles");
   plain_slot_a: assert property (cmd_go && WDATA[3:0] != 4'h9
         |-> ##2 !ARREADY [*2] ##1 ARREADY)
      else $error("single cycle op wrong length");
endmodule

bind mis_alu_top mis_alu_chk #(.DOG_LIMIT(DOG_LIMIT)) i_chk (
   .MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
   .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
   .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
);
`default_nettype wire

/* File: dv/mcu_instruction_semantics_a_to_c_tb.sv */
// self-checking bench for the instruction datapath slice
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_semantics_a_to_c_tb
   import mis_pkg::*;
;
   logic MCLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [4:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, v;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP;
   logic [9:0] pc;
   int fail_count, checked, n0, n1;

   mis_alu_top #(.DOG_LIMIT(200)) i_dut (
      .MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
   );

   initial
   begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end

   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", n, e, s);
      end
   endtask

   // trailing edge keeps two drives of one strobe out of one time step
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge MCLK);
         if (!aw && AWREADY)
         begin
            aw = 1'b1;
            AWVALID <= 1'b0;
         end
         if (!w && WREADY)
         begin
            w = 1'b1;
            WVALID <= 1'b0;
         end
      end
      do @(posedge MCLK); while (!BVALID);
      BREADY <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do @(posedge MCLK); while (!ARREADY);
      ARVALID <= 1'b0;
      do @(posedge MCLK); while (!RVALID);
      d = RDATA;
      RREADY <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic gap(output int n);
      n = 0;
      while (ARREADY !== 1'b1)
      begin
         @(posedge MCLK);
         n++;
      end
   endtask

   // one instruction on memory byte 2A, expectations built here
   task automatic op(input logic [3:0] o, input logic [7:0] w, m, im,
                     input logic [2:0] bi, input logic [4:0] st);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] b, ew, em;
      logic [3:0] f;
      logic ci;
      ci = (o == 4'h1 || o == 4'h2) ? st[0] : 1'b0;
      b = (o == 4'h4 || o == 4'h7) ? im : m;
      s = w + b + ci;
      h = w[3:0] + b[3:0] + ci;
      ew = w;
      em = m;
      f = st[3:0];
      case (o)
         4'h1, 4'h3, 4'h4: ew = s[7:0];
         4'h2, 4'h5: em = s[7:0];
         4'h6, 4'h7: ew = w & b;
         4'h8: em = w & m;
         4'hA: em = 8'h00;
         4'hB: em[bi] = 1'b0;
         4'hD: em = ~m;
         default: ;
      endcase
      if (o >= 4'h1 && o <= 4'h5)
         f = {(w[7] == b[7]) && (s[7] != w[7]), s[7:0] == 8'h00, h[4], s[8]};
      if (o == 4'h6 || o == 4'h7)
         f[2] = ew == 8'h00;
      if (o == 4'h8 || o == 4'hD)
         f[2] = em == 8'h00;
      wr(OFS_WREG, {24'h0, w});
      wr(OFS_MADDR, 32'h2A);
      wr(OFS_MDATA, {24'h0, m});
      wr(OFS_STAT, {27'h0, st});
      wr(OFS_CMD, {6'h00, 2'h0, im, 2'h0, 6'h2A, 1'b0, bi, o});
      pc = pc + 10'h001;
      rd(OFS_WREG, v);
      cmp("wreg", ew, v[7:0]);
      rd(OFS_MDATA, v);
      cmp("mem", em, v[7:0]);
      rd(OFS_STAT, v);
      cmp("flags", {st[4], f}, v[4:0]);
      rd(OFS_PC, v);
      cmp("pc", pc, v[9:0]);
      $display("op %0h done", o);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #800000;
      fail_count++;
      final_report();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      RST_N = 1'b0;
      AWVALID = 1'b0;
      WVALID = 1'b0;
      BREADY = 1'b0;
      ARVALID = 1'b0;
      RREADY = 1'b0;
      AWADDR = 5'h00;
      ARADDR = 5'h00;
      WDATA = 32'h0;
      WSTRB = 4'hF;
      pc = 10'h000;
      repeat (20) @(posedge MCLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      rd(OFS_WREG, v);
      cmp("wreg_rst", 32'h0, v);
      rd(OFS_STACK, v);
      cmp("stack_rst", 32'h0, v);
      $display("reset test done");
      op(4'h1, 8'hFF, 8'h00, 8'h00, 3'h0, 5'h01);
      op(4'h1, 8'h7F, 8'h00, 8'h00, 3'h0, 5'h01);
      op(4'h2, 8'h88, 8'h88, 8'h00, 3'h0, 5'h01);
      op(4'h3, 8'h0F, 8'h01, 8'h00, 3'h0, 5'h1F);
      op(4'h4, 8'h80, 8'h55, 8'h80, 3'h0, 5'h01);
      op(4'h5, 8'h12, 8'h34, 8'h00, 3'h0, 5'h0F);
      op(4'h5, 8'hF0, 8'h20, 8'h00, 3'h0, 5'h00);
      op(4'h6, 8'hF0, 8'h0F, 8'h00, 3'h0, 5'h1F);
      op(4'h7, 8'h3C, 8'hFF, 8'h0F, 3'h0, 5'h04);
      op(4'h8, 8'hAA, 8'hF0, 8'h00, 3'h0, 5'h04);
      op(4'hA, 8'h11, 8'h5A, 8'h00, 3'h0, 5'h0F);
      for (int i = 0; i < 8; i++)
         op(4'hB, 8'h00, 8'hFF, 8'h00, 3'(i), 5'h0A);
      op(4'hD, 8'h00, 8'hFF, 8'h00, 3'h0, 5'h0B);
      op(4'hD, 8'h00, 8'h00, 8'h00, 3'h0, 5'h1F);
      op(4'h0, 8'h33, 8'h44, 8'h00, 3'h0, 5'h05);
      op(4'hF, 8'h33, 8'h44, 8'h00, 3'h0, 5'h1A);
      wr(OFS_CMD, 32'h0);
      gap(n0);
      wr(OFS_PC, 32'h3FF);
      wr(OFS_STAT, 32'h0B);
      wr(OFS_CMD, 32'h0155_0009);
      gap(n1);
      cmp("call_len", n0 + 1, n1);
      rd(OFS_PC, v);
      cmp("call_pc", 32'h155, v);
      rd(OFS_STACK, v);
      cmp("push_wrap", 32'h0001_0000, v);
      wr(OFS_CMD, 32'h02AA_0009);
      rd(OFS_STACK, v);
      cmp("push_next", 32'h0002_0156, v);
      rd(OFS_CMD, v);
      cmp("cmd_back", 32'h02AA_0009, v);
      rd(OFS_STAT, v);
      cmp("call_flags", 5'h0B, v[4:0]);
      $display("call test done");
      v = 32'h0;
      repeat (60)
         if (v[5] !== 1'b1)
            rd(OFS_STAT, v);
      cmp("dog_expired", 1'b1, v[5]);
      wr(OFS_STAT, 32'h10);
      wr(OFS_CMD, 32'h0000_000C);
      // second clear: the first may land on an expiry edge, where expiry wins
      wr(OFS_CMD, 32'h0000_000C);
      rd(OFS_STAT, v);
      cmp("dog_flags", 2'h0, v[5:4]);
      rd(OFS_DOG, v);
      cmp("dog_count", 1'b1, v[15:0] < 16'd20);
      $display("watchdog test done");
      final_report();
   end
endmodule
`default_nettype wire
